// file: rtl/amc_defs.svh
`ifndef AMC_DEFS_SVH
`define AMC_DEFS_SVH
// Clock rate in MHz; cycle counts are derived from microsecond times.
`define AMC_CLK_MHZ 25
`define AMC_CYC(us) ((us) * `AMC_CLK_MHZ)
// Unspecified delays, in microseconds.
`define AMC_T_INIT_US 10
`define AMC_T_REBOOT_US 50
`define AMC_T_RESTART_US 20
`define AMC_T_HOLDUP_US 5
`define AMC_T_CLIP_US 2
`define AMC_T_STEP_US 4
// Register byte offsets.
`define AMC_OFF_CTRL 12'h000
`define AMC_OFF_STATUS 12'h004
// Control field positions and reset value.
`define AMC_CTRL_STBY 0
`define AMC_CTRL_MUTE 1
`define AMC_CTRL_RST 32'h00000000
// Status field positions.
`define AMC_ST_STATE 0
`define AMC_ST_LEVEL 4
`define AMC_ST_PROT 8
`define AMC_ST_CLIP 9
`define AMC_ST_AMP 11
`define AMC_ST_AUX 12
`define AMC_ST_CTL 13
`endif

// file: rtl/amc_pkg.sv
package amc_pkg;
    // Sequencer states.
    typedef enum logic [3:0] {
        AMC_INIT, AMC_CHECK, AMC_REBOOT, AMC_RUN, AMC_STBY,
        AMC_FAULT, AMC_AUX, AMC_CTRL, AMC_RESTART
    } amc_state_t;
    // Condition inputs from the module's sensors, all asynchronous.
    typedef struct packed {
        logic selfcheck_err;
        logic near_thermal;
        logic supply_ovl;
        logic supersonic;
        logic speaker_ovl;
        logic f_supply;
        logic f_amp_short;
        logic f_overtemp;
        logic f_sonic;
        logic f_aux;
        logic f_ctrl;
        logic amp_temp_ok;
        logic psu_temp_ok;
    } amc_sense_t;
    // Supply and amplifier enables driven out.
    typedef struct packed {
        logic amp_enable;
        logic aux_supply_en;
        logic control_supply_en;
        logic supply_low_power;
    } amc_power_t;
endpackage : amc_pkg

// file: rtl/amc_ctrl.sv
// Function
// - Initialise, sample inputs, run with inputs open
// - Self-check at power-up, reboot after delay
// - Progressive limiting on three load conditions
// - Shut down when limiting fails, auto restart
// - Speaker overload limits first, then shuts down
// - Standby request high enters standby
// - Standby: amp off, aux off, control low-power
// - Mute high stops amplifier, supplies stay
// - Open mute input means amplifier runs
// - Saturation flag low, stretched to minimum
// - Single-channel build releases channel two flag
// - Protection flag low during fault shutdown
// - Resume after clear; overtemp waits release
// - Control overload: full power cycle, brief flag
// - Aux overload stops amp and aux, restarts
//
// Local design decisions: the address map and register access over APB.
`include "amc_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module amc_ctrl
    import amc_pkg::*;
#(
    parameter int CHANNELS = 2,
    parameter int INIT_CYC = `AMC_CYC(`AMC_T_INIT_US),
    parameter int REBOOT_CYC = `AMC_CYC(`AMC_T_REBOOT_US),
    parameter int RESTART_CYC = `AMC_CYC(`AMC_T_RESTART_US),
    parameter int HOLDUP_CYC = `AMC_CYC(`AMC_T_HOLDUP_US),
    parameter int CLIP_CYC = `AMC_CYC(`AMC_T_CLIP_US),
    parameter int STEP_CYC = `AMC_CYC(`AMC_T_STEP_US)
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic standby_req_in,
    input wire logic amplifier_mute_in,
    input wire logic [1:0] clip_in,
    input wire amc_sense_t sense_in,
    output amc_power_t power_out,
    output logic limit_active,
    output logic ch1_saturation_flag,
    output logic ch2_saturation_flag,
    output logic protection_flag_n
);
    // Counters are 16 bits wide, so every delay must fit; refused at elaboration.
    if (CHANNELS < 1 || CHANNELS > 2 || INIT_CYC < 1 || REBOOT_CYC < 1
        || RESTART_CYC < 1 || HOLDUP_CYC < 1 || CLIP_CYC < 1 || STEP_CYC < 1
        || INIT_CYC > 65535 || REBOOT_CYC > 65535 || RESTART_CYC > 65535
        || HOLDUP_CYC > 65535 || CLIP_CYC > 65535 || STEP_CYC > 65535)
    begin : g_param_check
        $error("amc_ctrl: unsupported parameter value.");
    end

    localparam int NS = $bits(amc_sense_t) + 4;
    localparam logic [15:0] INIT_N = 16'(INIT_CYC - 1);
    localparam logic [15:0] REBOOT_N = 16'(REBOOT_CYC - 1);
    localparam logic [15:0] RESTART_N = 16'(RESTART_CYC - 1);
    localparam logic [15:0] HOLDUP_N = 16'(HOLDUP_CYC);
    localparam logic [15:0] CLIP_N = 16'(CLIP_CYC);
    localparam logic [15:0] STEP_N = 16'(STEP_CYC - 1);

    logic [NS-1:0] raw_in; // All pin inputs side by side.
    logic [NS-1:0] sync_a; // First synchroniser stage, read only by sync_b.
    logic [NS-1:0] sync_b; // Second stage, safe to use.
    amc_sense_t sn; // Synchronised sensor conditions.
    logic stby_pin; // Synchronised standby request.
    logic mute_pin; // Synchronised mute request.
    logic [1:0] clip_s; // Synchronised clip detectors.
    amc_state_t state; // Sequencer state.
    logic [15:0] cnt; // Delay counter for the current state.
    logic [15:0] step_cnt; // Divider for the limiting step pulse.
    logic step; // One-cycle limiting step enable.
    logic [2:0] level; // Progressive limiting depth.
    logic ot_seen; // Overtemperature caused the current shutdown.
    logic [31:0] ctrl; // Software control register.
    logic [1:0] clip_flag_n; // Stretched saturation flags, active low.
    logic lim_cond; // Any condition that calls for limiting.
    logic hard_fault; // Conditions that shut the amplifier down at once.
    logic trip; // Limiting is saturated and not enough.

    assign raw_in = {sense_in, standby_req_in, amplifier_mute_in, clip_in};

    // Every pin input passes two flip-flops before logic reads it.
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++)
        begin : g_sync
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                end
                else
                begin
                    sync_a[gi] <= raw_in[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    // Reset value zero is also the pull-down default of open inputs.
    assign {sn, stby_pin, mute_pin, clip_s} = sync_b;

    // Limiting covers thermal, supply and super-sonic load, plus speaker
    // overload, which thereby limits before it can shut down.
    assign lim_cond = sn.near_thermal | sn.supply_ovl | sn.supersonic
        | sn.speaker_ovl;
    assign hard_fault = sn.f_supply | sn.f_amp_short | sn.f_overtemp | sn.f_sonic;
    assign trip = (level == 3'h7) && lim_cond && step;

    // Step divider; limiting ramps one level per step, so short bursts
    // only clip lightly rather than shutting the module down.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            step_cnt <= 16'h0000;
        else if (step)
            step_cnt <= 16'h0000;
        else
            step_cnt <= step_cnt + 16'h0001;
    end
    assign step = (step_cnt == STEP_N);

    // Limiting level rises while a load condition stands, falls otherwise.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            level <= 3'h0;
        else if (state != AMC_RUN)
            level <= 3'h0;
        else if (step && lim_cond && level != 3'h7)
            level <= level + 3'h1;
        else if (step && !lim_cond && level != 3'h0)
            level <= level - 3'h1;
    end

    // Main sequencer and its delay counter.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= AMC_INIT;
            cnt <= 16'h0000;
            ot_seen <= 1'b0;
        end
        else
        begin
            cnt <= cnt + 16'h0001;
            case (state)
                AMC_INIT:
                    // Short initialisation before inputs are looked at.
                    if (cnt == INIT_N)
                    begin
                        state <= AMC_CHECK;
                        cnt <= 16'h0000;
                    end
                AMC_CHECK:
                begin
                    // Self-check verdict decides run or reboot.
                    cnt <= 16'h0000;
                    if (sn.selfcheck_err || hard_fault || sn.f_ctrl)
                        state <= AMC_REBOOT;
                    else
                        state <= AMC_RUN;
                end
                AMC_REBOOT:
                    if (cnt == REBOOT_N)
                    begin
                        state <= AMC_INIT;
                        cnt <= 16'h0000;
                    end
                AMC_RUN:
                begin
                    cnt <= 16'h0000;
                    // Control supply overload wins: it takes everything down.
                    if (sn.f_ctrl)
                        state <= AMC_CTRL;
                    else if (hard_fault || trip)
                    begin
                        state <= AMC_FAULT;
                        ot_seen <= sn.f_overtemp;
                    end
                    else if (sn.f_aux)
                        state <= AMC_AUX;
                    else if (stby_pin || ctrl[`AMC_CTRL_STBY])
                        state <= AMC_STBY;
                end
                AMC_STBY:
                begin
                    cnt <= 16'h0000;
                    if (sn.f_ctrl)
                        state <= AMC_CTRL;
                    else if (!stby_pin && !ctrl[`AMC_CTRL_STBY])
                        state <= AMC_RUN;
                end
                AMC_FAULT:
                begin
                    cnt <= 16'h0000;
                    ot_seen <= ot_seen | sn.f_overtemp;
                    // Overtemperature also needs both release thresholds.
                    if (sn.f_ctrl)
                        state <= AMC_CTRL;
                    else if (!hard_fault && !lim_cond
                        && (!ot_seen || (sn.amp_temp_ok && sn.psu_temp_ok)))
                        state <= AMC_RESTART;
                end
                AMC_AUX:
                begin
                    cnt <= 16'h0000;
                    if (sn.f_ctrl)
                        state <= AMC_CTRL;
                    else if (!sn.f_aux)
                        state <= AMC_RESTART;
                end
                AMC_CTRL:
                    // Full power-down, then a fresh power-up.
                    if (cnt == REBOOT_N)
                    begin
                        state <= AMC_INIT;
                        cnt <= 16'h0000;
                    end
                AMC_RESTART:
                    if (cnt == RESTART_N)
                    begin
                        state <= AMC_RUN;
                        cnt <= 16'h0000;
                        ot_seen <= 1'b0;
                    end
                default:
                begin
                    state <= AMC_INIT;
                    cnt <= 16'h0000;
                end
            endcase
        end
    end

    // Supply and amplifier enables, registered from the state.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            power_out <= '0;
            limit_active <= 1'b0;
            protection_flag_n <= 1'b1;
        end
        else
        begin
            // Mute stops only the amplifier; every supply keeps running.
            power_out.amp_enable <= (state == AMC_RUN)
                && !mute_pin && !ctrl[`AMC_CTRL_MUTE];
            // Standby and aux overload keep only the control supplies.
            power_out.aux_supply_en <= (state == AMC_RUN)
                || (state == AMC_RESTART) || (state == AMC_FAULT);
            power_out.control_supply_en <= (state != AMC_CTRL);
            power_out.supply_low_power <= (state == AMC_STBY);
            limit_active <= (state == AMC_RUN) && (level != 3'h0);
            // Open-collector flag: low asserts, high is released.
            protection_flag_n <= !((state == AMC_FAULT) || (state == AMC_AUX)
                || (state == AMC_CTRL && cnt < HOLDUP_N));
        end
    end

    // Per-channel stretchers keep short clips visible on a lamp.
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_clip
            logic [15:0] hold; // Cycles left of the minimum low time.
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    hold <= 16'h0000;
                    clip_flag_n[gi] <= 1'b1;
                end
                else if (gi >= CHANNELS)
                begin
                    hold <= 16'h0000;
                    clip_flag_n[gi] <= 1'b1;
                end
                else if (clip_s[gi])
                begin
                    hold <= CLIP_N - 16'h0001;
                    clip_flag_n[gi] <= 1'b0;
                end
                else if (hold != 16'h0000)
                begin
                    hold <= hold - 16'h0001;
                    clip_flag_n[gi] <= 1'b0;
                end
                else
                    clip_flag_n[gi] <= 1'b1;
            end
        end
    endgenerate
    assign ch1_saturation_flag = clip_flag_n[0];
    assign ch2_saturation_flag = clip_flag_n[1];

    // APB slave: zero wait states; unmapped addresses raise pslverr.
    assign pready = 1'b1;
    always_comb
    begin
        pslverr = 1'b0;
        prdata = 32'h00000000;
        if (psel && penable)
        begin
            case (paddr)
                `AMC_OFF_CTRL:
                    prdata = ctrl;
                `AMC_OFF_STATUS:
                begin
                    prdata[`AMC_ST_STATE +: 4] = state;
                    prdata[`AMC_ST_LEVEL +: 3] = level;
                    prdata[`AMC_ST_PROT] = !protection_flag_n;
                    prdata[`AMC_ST_CLIP +: 2] = ~clip_flag_n;
                    prdata[`AMC_ST_AMP] = power_out.amp_enable;
                    prdata[`AMC_ST_AUX] = power_out.aux_supply_en;
                    prdata[`AMC_ST_CTL] = power_out.control_supply_en;
                end
                default:
                    pslverr = 1'b1;
            endcase
        end
    end

    // Control register; only the two defined bits are stored.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= `AMC_CTRL_RST;
        else if (psel && penable && pwrite && paddr == `AMC_OFF_CTRL)
            ctrl <= pwdata & 32'h00000003;
    end

    // Length of the current low phase of channel one, for checking; in the
    // cycle after the flag is released it still holds the full low length.
    logic [15:0] low_len;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            low_len <= 16'h0000;
        else if (!ch1_saturation_flag)
            low_len <= low_len + 16'h0001;
        else
            low_len <= 16'h0000;
    end

    a_init_len: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state == AMC_CHECK) |-> $past(state) == AMC_INIT && $past(cnt) == INIT_N)
        else $error("Initialisation ended early.");
    a_check_reboot: assert property (@(posedge pclk) disable iff (!presetn)
        state == AMC_CHECK && sn.selfcheck_err |=> state == AMC_REBOOT)
        else $error("Self-check error did not reboot.");
    a_limit_trip: assert property (@(posedge pclk) disable iff (!presetn)
        state == AMC_RUN && trip && !sn.f_ctrl |=> state == AMC_FAULT ##1 !protection_flag_n)
        else $error("Saturated limiting did not shut down.");
    a_stby_power: assert property (@(posedge pclk) disable iff (!presetn)
        state == AMC_STBY |=> !power_out.amp_enable && !power_out.aux_supply_en
        && power_out.supply_low_power && power_out.control_supply_en)
        else $error("Standby outputs wrong.");
    a_mute_amp: assert property (@(posedge pclk) disable iff (!presetn)
        state == AMC_RUN && mute_pin |=> !power_out.amp_enable && power_out.aux_supply_en)
        else $error("Mute did not stop only the amplifier.");
    a_clip_min: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ch1_saturation_flag) |-> low_len >= CLIP_N)
        else $error("Saturation flag low pulse too short.");
    a_ch2_open: assert property (@(posedge pclk) disable iff (!presetn)
        CHANNELS == 1 |-> ch2_saturation_flag)
        else $error("Channel two flag driven in single-channel build.");
    a_ot_release: assert property (@(posedge pclk) disable iff (!presetn)
        state == AMC_FAULT && ot_seen && !sn.amp_temp_ok |=> state != AMC_RESTART)
        else $error("Restart before overtemperature release.");
    a_ctrl_holdup: assert property (@(posedge pclk) disable iff (!presetn)
        state == AMC_CTRL && cnt == HOLDUP_N |=> protection_flag_n && !power_out.control_supply_en)
        else $error("Protection flag outlived control hold-up.");
endmodule : amc_ctrl
`default_nettype wire

// file: tb/amc_front_end.sv
`timescale 1ns/100ps
`default_nettype none
// Behavioural front-end board: it drives the control inputs and times the clip flag.
module amc_front_end
    import amc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic want_standby,
    input wire logic want_mute,
    input wire logic ch1_saturation_flag,
    output logic standby_req_in,
    output logic amplifier_mute_in,
    output logic control_load_low,
    output logic [31:0] clip_low_len
)
;
    logic [31:0] run_len; // Cycles the flag has been low so far.

    // The control load is cut one cycle before standby is requested, so the
    // reduced standby supply is not overloaded by the board on entry; on exit the load returns in the same cycle as the request drops.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            control_load_low <= 1'b0;
            standby_req_in <= 1'b0;
            amplifier_mute_in <= 1'b0;
        end
        else
        begin
            control_load_low <= want_standby;
            standby_req_in <= want_standby & control_load_low;
            amplifier_mute_in <= want_mute;
        end
    end

    // The open-collector flag reads high when released; measure each low pulse.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_len <= 32'h0;
            clip_low_len <= 32'h0;
        end
        else if (ch1_saturation_flag === 1'b0)
        begin
            run_len <= run_len + 32'h1;
        end
        else if (run_len != 32'h0)
        begin
            clip_low_len <= run_len;
            run_len <= 32'h0;
        end
    end
endmodule : amc_front_end
`default_nettype wire

// file: tb/amc_module_control_status_bench.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench: one task per scenario, short delays for a quick run.
module amp_module_control_status_bench;
    import amc_pkg::*;
    `include "amc_defs.svh"
    localparam int STEP = 4; // Limiting step, in cycles.
    localparam int RST = 8; // Restart delay, in cycles.
    localparam int CLIP = 6; // Minimum clip pulse, in cycles.
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic want_standby = 1'b0;
    logic want_mute = 1'b0;
    logic standby_req_in;
    logic amplifier_mute_in;
    logic [1:0] clip_in = 2'h0;
    amc_sense_t sense = 13'h0003; // Both temperatures start in range.
    amc_power_t pw;
    logic limit_active;
    logic ch1_saturation_flag;
    logic ch2_saturation_flag;
    logic protection_flag_n;
    logic [31:0] clip_len;
    logic load_low; // The board has cut its control supply load.
    logic ch2_single; // Channel two flag of the single-channel build.
    logic [31:0] rd;
    logic er;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;

    // Free-running 25 MHz clock.
    always #20 pclk = ~pclk;

    amc_ctrl #(.CHANNELS(2), .INIT_CYC(8), .REBOOT_CYC(10), .RESTART_CYC(RST),
        .HOLDUP_CYC(4), .CLIP_CYC(CLIP), .STEP_CYC(STEP)) DUT (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .standby_req_in(standby_req_in),
        .amplifier_mute_in(amplifier_mute_in), .clip_in(clip_in), .sense_in(sense),
        .power_out(pw), .limit_active(limit_active),
        .ch1_saturation_flag(ch1_saturation_flag),
        .ch2_saturation_flag(ch2_saturation_flag),
        .protection_flag_n(protection_flag_n));

    // Single-channel build on the same stimulus; only its channel two flag is watched.
    amc_ctrl #(.CHANNELS(1), .INIT_CYC(8), .REBOOT_CYC(10), .RESTART_CYC(RST),
        .HOLDUP_CYC(4), .CLIP_CYC(CLIP), .STEP_CYC(STEP)) DUT_single (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
        .standby_req_in(standby_req_in), .amplifier_mute_in(amplifier_mute_in),
        .clip_in(clip_in), .sense_in(sense), .power_out(), .limit_active(),
        .ch1_saturation_flag(), .ch2_saturation_flag(ch2_single),
        .protection_flag_n());

    amc_front_end board (.pclk(pclk), .presetn(presetn), .want_standby(want_standby),
        .want_mute(want_mute), .ch1_saturation_flag(ch1_saturation_flag),
        .standby_req_in(standby_req_in), .amplifier_mute_in(amplifier_mute_in),
        .control_load_low(load_low), .clip_low_len(clip_len));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Selects one observed output, so that one wait task serves all of them.
    function automatic logic probe(input int k);
        case (k)
            0: return pw.amp_enable;
            1: return pw.aux_supply_en;
            2: return pw.control_supply_en;
            3: return pw.supply_low_power;
            4: return protection_flag_n;
            default: return limit_active;
        endcase
    endfunction : probe

    // Waits on settled values at the falling edge, bounded by lim cycles, and
    // returns just after a rising edge so that the next drive lands there.
    task automatic wt(input int k, input logic v, input int lim);
        int n;
        n = 0;
        @(negedge pclk);
        while (probe(k) !== v && n < lim)
        begin
            @(negedge pclk);
            n++;
        end
        chk($sformatf("output %0d", k), {31'h0, probe(k)}, {31'h0, v});
        @(posedge pclk);
    endtask : wt

    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic t_regs;
        apb(1'b0, `AMC_OFF_CTRL, 32'h0);
        chk("ctrl reset", rd, `AMC_CTRL_RST);
        apb(1'b1, `AMC_OFF_CTRL, 32'hffffffff);
        apb(1'b0, `AMC_OFF_CTRL, 32'h0);
        chk("ctrl bits", rd, 32'h3);
        apb(1'b1, `AMC_OFF_CTRL, 32'h0);
        apb(1'b0, `AMC_OFF_STATUS, 32'h0);
        chk("state run", rd & 32'hf, 32'(AMC_RUN));
        apb(1'b0, 12'h008, 32'h0);
        chk("unmapped err", {31'h0, er}, 32'h1);
    endtask : t_regs

    // Standby cuts amp and aux, keeps the control supply in low power.
    task automatic t_standby;
        want_standby <= 1'b1;
        wt(3, 1'b1, 20);
        chk("stby", {pw.amp_enable, pw.aux_supply_en, pw.control_supply_en}, 32'h1);
        chk("load cut", {31'h0, load_low}, 32'h1);
        want_standby <= 1'b0;
        wt(0, 1'b1, 80);
    endtask : t_standby

    // Mute stops only the amplifier.
    task automatic t_mute;
        want_mute <= 1'b1;
        wt(0, 1'b0, 20);
        chk("mute", {pw.aux_supply_en, pw.control_supply_en, pw.supply_low_power}, 32'h6);
        want_mute <= 1'b0;
        wt(0, 1'b1, 20);
    endtask : t_mute

    // A short and a long clip on both channels. Each flag stays low through the
    // clip and CLIP-1 cycles after it; the single-channel build keeps its
    // channel two flag released.
    task automatic t_clip(input int len);
        @(posedge pclk);
        clip_in <= 2'h3;
        repeat (len) @(posedge pclk);
        clip_in <= 2'h0;
        repeat (3) @(posedge pclk);
        chk("ch2 low", {31'h0, ch2_saturation_flag}, 32'h0);
        chk("single ch2", {31'h0, ch2_single}, 32'h1);
        repeat (CLIP + 5) @(posedge pclk);
        chk("clip length", clip_len, len + CLIP - 1);
        chk("ch2 idle", {31'h0, ch2_saturation_flag}, 32'h1);
    endtask : t_clip

    // A limit condition raises the level, then shuts down when it persists.
    task automatic t_limit(input int b);
        sense[b] <= 1'b1;
        wt(5, 1'b1, 3 * STEP);
        chk("no prot yet", {31'h0, protection_flag_n}, 32'h1);
        wt(4, 1'b0, 8 * STEP + 8);
        sense[b] <= 1'b0;
        wt(4, 1'b1, RST + 10);
        wt(0, 1'b1, 10);
    endtask : t_limit

    // Hard faults shut down with protect low and resume after clearing.
    task automatic t_fault(input int b);
        sense[b] <= 1'b1;
        wt(4, 1'b0, 10);
        chk("amp off", {31'h0, pw.amp_enable}, 32'h0);
        repeat (2 * RST) @(posedge pclk);
        chk("held", {31'h0, protection_flag_n}, 32'h0);
        sense[b] <= 1'b0;
        if (b == 5)
        begin
            repeat (2 * RST) @(posedge pclk);
            chk("temp wait", {31'h0, protection_flag_n}, 32'h0);
            sense[1] <= 1'b1;
        end
        wt(4, 1'b1, RST + 10);
        wt(0, 1'b1, 10);
    endtask : t_fault

    // Aux overload keeps the control supply; control overload power-cycles.
    task automatic t_supplies;
        sense[3] <= 1'b1;
        wt(1, 1'b0, 10);
        chk("aux ovl", {pw.amp_enable, pw.control_supply_en, protection_flag_n}, 32'h2);
        sense[3] <= 1'b0;
        wt(1, 1'b1, 3 * RST);
        wt(0, 1'b1, 10);
        sense[2] <= 1'b1;
        wt(2, 1'b0, 10);
        chk("ctrl prot", {31'h0, protection_flag_n}, 32'h0);
        wt(4, 1'b1, 10);
        chk("still off", {31'h0, pw.control_supply_en}, 32'h0);
        sense[2] <= 1'b0;
        wt(0, 1'b1, 60);
    endtask : t_supplies

    // A failing self-check keeps the amplifier off until it passes.
    task automatic t_boot;
        presetn <= 1'b0;
        sense[12] <= 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (60) @(posedge pclk);
        chk("boot blocked", {31'h0, pw.amp_enable}, 32'h0);
        sense[12] <= 1'b0;
        wt(0, 1'b1, 60);
    endtask : t_boot

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    // Cuts a hang short.
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            end_of_test();
        end
    end

    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        wt(0, 1'b1, 60);
        chk("idle", {pw.aux_supply_en, protection_flag_n}, 32'h3);
        t_regs();
        t_standby();
        t_mute();
        t_clip(1);
        t_clip(20);
        t_limit(11);
        t_limit(10);
        t_limit(9);
        t_limit(8);
        sense[1] <= 1'b0;
        t_fault(5);
        t_fault(7);
        t_fault(6);
        t_fault(4);
        t_supplies();
        t_boot();
        end_of_test();
    end
endmodule : amp_module_control_status_bench
`default_nettype wire
